// ===== hdl/timer_pkg.sv
package timer_pkg;

  // ****************************************************************
  // bus geometry and answers
  // ****************************************************************
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W = 6;
  localparam int unsigned IDX_LSB = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [IDX_W-1:0] IDX_IO_SELECT = 6'h00;
  localparam logic [IDX_W-1:0] IDX_COUNT_HI = 6'h04;
  localparam logic [IDX_W-1:0] IDX_COUNT_LO = 6'h05;
  localparam logic [IDX_W-1:0] IDX_CTRL_ONE = 6'h06;
  localparam logic [IDX_W-1:0] IDX_CHAN_MASK = 6'h0C;
  localparam logic [IDX_W-1:0] IDX_CTRL_TWO = 6'h0D;
  localparam logic [IDX_W-1:0] IDX_CHAN_FLAGS = 6'h0E;
  localparam logic [IDX_W-1:0] IDX_OVF_FLAGS = 6'h0F;
  localparam logic [IDX_W-1:0] IDX_CMP7_HI = 6'h1E;
  localparam logic [IDX_W-1:0] IDX_CMP7_LO = 6'h1F;
  localparam logic [IDX_W-1:0] IDX_PACC_CTRL = 6'h20;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 6'h30;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 6'h31;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 6'h32;
  // channel value window: indices 0x10..0x1F, two per channel
  localparam logic [1:0] CHAN_WIN_TAG = 2'h1;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned CTRL1_TIMER_EN = 7;
  localparam int unsigned CTRL1_FAST_CLR = 4;
  localparam int unsigned CTRL2_OVF_IE = 7;
  localparam int unsigned CTRL2_CNT_RST = 3;
  localparam int unsigned DIV_W = 3;
  localparam int unsigned OVF_FLAG_BIT = 7;
  localparam int unsigned PACC_EN_BIT = 6;
  localparam int unsigned IRQ_OVF_BIT = 8;
  localparam int unsigned CHANNELS = 8;
  localparam int unsigned CMP_CHANNEL = 7;
  localparam int unsigned CNT_W = 16;

  // ****************************************************************
  // reset values and counter limits
  // ****************************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [DIV_W-1:0] RST_DIV = 3'h0;
  localparam logic [CNT_W-1:0] RST_COUNT = 16'h0000;
  localparam logic [CNT_W-1:0] COUNT_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] COUNT_ONE = 16'h0001;
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
  localparam int unsigned PRESCALE_STAGES = 7;

endpackage

// ===== hdl/timer_prescaler.sv
`timescale 1ns/100ps

// ******************************************************************
// prescaler: divides the bus clock by two to the select value
// ******************************************************************
module timer_prescaler
  import timer_pkg::*;
#(
  parameter int unsigned STAGES = PRESCALE_STAGES
) (
  input wire logic aclk, // bus clock
  input wire logic aresetn, // synchronous reset, low
  input wire logic run, // counting allowed
  input wire logic restart, // force all stages to zero
  input wire logic [DIV_W-1:0] div_select, // requested divider
  output logic tick // one-cycle timer clock enable
);

  if (STAGES < (1 << DIV_W) - 1) begin : g_check
    $error("prescaler needs at least 7 stages");
  end

  typedef struct packed {
    logic [STAGES-1:0] stage;
    logic [DIV_W-1:0] active;
  } pre_s;

  pre_s q, d;
  logic [STAGES-1:0] mask;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    d = q;
    mask = STAGES'((1 << q.active) - 1);
    tick = run && ((q.stage & mask) == mask);
    // new factor only taken while all stages read zero
    if (q.stage == '0) begin
      d.active = div_select;
    end
    if (!run || restart) begin
      d.stage = '0;
    end else begin
      d.stage = q.stage + STAGES'(1);
    end
  end

  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '{stage: '0, active: RST_DIV};
    end else begin
      q <= d;
    end
  end

endmodule // timer_prescaler

// ===== hdl/timer_prescale_and_flags.sv
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/100ps

// Contract
// - overflow interrupt when enabled and flag set
// - compare-7 match resets counter when enabled
// - compare value zero holds counter at zero
// - match reset from all ones sets no overflow
// - period is compare times divider plus one
// - divider is two to the select value
// - new divider applied when prescaler stages zero
// - channel events set channel flags
// - write one clears flag while timer/accumulator on
// - writing zero leaves channel flag unchanged
// - fast clear on capture read, compare write
// - fast clear: counter access clears overflow
// - counter wrap sets overflow flag
// - overflow flag cleared by one, when enabled
// - channel mask gates channel flag interrupts
module timer_prescale_and_flags
  import timer_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic aclk, // bus clock
  input wire logic aresetn, // synchronous reset, low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic [2:0] s_axi_awprot, // unused protection
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [DATA_W-1:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic [2:0] s_axi_arprot, // unused protection
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [DATA_W-1:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [CHANNELS-1:0] chan_event, // channel event strobes
  output logic [CNT_W-1:0] free_counter, // running count
  output logic irq // level interrupt
);

  if (ADDR_W < IDX_W + IDX_LSB) begin : g_check
    $error("address too narrow for the register map");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [IDX_W-1:0] widx;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [CHANNELS-1:0] io_select;
    logic timer_enable;
    logic fast_flag_clear;
    logic [CHANNELS-1:0] channel_irq_mask;
    logic overflow_irq_enable;
    logic counter_reset_on_match;
    logic [DIV_W-1:0] clock_divider_select;
    logic pulse_acc_enable;
    logic [CHANNELS-1:0] chan_flags;
    logic overflow_flag;
    logic [CNT_W-1:0] counter;
    logic [CNT_W-1:0] compare7_value;
    logic irq;
  } state_s;

  state_s q, d;

  logic tick;
  logic match;
  logic clear_ok;
  logic wr_do;
  logic rd_do;
  logic w_hit;
  logic r_hit;
  logic [IDX_W-1:0] ridx;
  logic [7:0] wbyte;
  logic [7:0] wmask;
  logic [CHANNELS-1:0] clr_ch;
  logic clr_ovf;
  logic set_ovf;
  logic [DATA_W-1:0] rd_val;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // byte merge under lane mask
  function automatic logic [7:0] merge8(input logic [7:0] old_v,
                                        input logic [7:0] new_v,
                                        input logic [7:0] m);
    merge8 = (old_v & ~m) | (new_v & m);
  endfunction

  // true when the index falls in the channel value window
  function automatic logic in_chan_win(input logic [IDX_W-1:0] idx);
    in_chan_win = (idx[IDX_W-1:IDX_W-2] == CHAN_WIN_TAG);
  endfunction

  // channel number of a window index (two indices per channel)
  function automatic logic [2:0] chan_of(input logic [IDX_W-1:0] idx);
    chan_of = idx[3:1];
  endfunction

  // ****************************************************************
  // prescaler
  // ****************************************************************
  timer_prescaler #(
    .STAGES(PRESCALE_STAGES)
  ) u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(q.timer_enable),
    .restart(match),
    .div_select(q.clock_divider_select),
    .tick(tick)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    d = q;
    clr_ch = '0;
    clr_ovf = 1'b0;
    w_hit = 1'b1;
    r_hit = 1'b1;
    rd_val = RST_WORD;
    wbyte = q.wdata[7:0];
    wmask = {8{q.wstrb[0]}};
    ridx = s_axi_araddr[IDX_LSB +: IDX_W];
    clear_ok = q.timer_enable || q.pulse_acc_enable;

    // write address and data are taken in either order
    if (q.awready && s_axi_awvalid) begin
      d.aw_held = 1'b1;
      d.awready = 1'b0;
      d.widx = s_axi_awaddr[IDX_LSB +: IDX_W];
    end
    if (q.wready && s_axi_wvalid) begin
      d.w_held = 1'b1;
      d.wready = 1'b0;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    wr_do = q.aw_held && q.w_held && !q.bvalid;

    // write decode
    if (wr_do) begin
      if (q.widx == IDX_IO_SELECT) begin
        d.io_select = merge8(q.io_select, wbyte, wmask);
      end else if (q.widx == IDX_CTRL_ONE) begin
        if (wmask[CTRL1_TIMER_EN]) begin
          d.timer_enable = wbyte[CTRL1_TIMER_EN];
        end
        if (wmask[CTRL1_FAST_CLR]) begin
          d.fast_flag_clear = wbyte[CTRL1_FAST_CLR];
        end
      end else if (q.widx == IDX_CHAN_MASK) begin
        d.channel_irq_mask = merge8(q.channel_irq_mask, wbyte, wmask);
      end else if (q.widx == IDX_CTRL_TWO) begin
        if (q.wstrb[0]) begin
          d.overflow_irq_enable = wbyte[CTRL2_OVF_IE];
          d.counter_reset_on_match = wbyte[CTRL2_CNT_RST];
          d.clock_divider_select = wbyte[DIV_W-1:0];
        end
      end else if (q.widx == IDX_CHAN_FLAGS) begin
        // zeros leave flags alone, ones clear when allowed
        clr_ch = wbyte & wmask & {CHANNELS{clear_ok}};
      end else if (q.widx == IDX_OVF_FLAGS) begin
        clr_ovf = wbyte[OVF_FLAG_BIT] && wmask[OVF_FLAG_BIT]
                  && clear_ok;
      end else if (q.widx == IDX_PACC_CTRL) begin
        if (wmask[PACC_EN_BIT]) begin
          d.pulse_acc_enable = wbyte[PACC_EN_BIT];
        end
      end else if (q.widx == IDX_COUNT_HI || q.widx == IDX_COUNT_LO) begin
        // counter is read-only; access still counts for fast clear
        clr_ovf = q.fast_flag_clear;
      end else if (in_chan_win(q.widx)) begin
        // compare channels only: writes to capture channels do nothing
        if (q.io_select[chan_of(q.widx)]) begin
          clr_ch[chan_of(q.widx)] = q.fast_flag_clear;
          if (q.widx == IDX_CMP7_HI) begin
            d.compare7_value[15:8] =
              merge8(q.compare7_value[15:8], wbyte, wmask);
          end else if (q.widx == IDX_CMP7_LO) begin
            d.compare7_value[7:0] =
              merge8(q.compare7_value[7:0], wbyte, wmask);
          end
        end
      end else if (q.widx == IDX_IRQ_CLEAR) begin
        clr_ch = wbyte & wmask & {CHANNELS{clear_ok}};
        clr_ovf = q.wdata[IRQ_OVF_BIT] && q.wstrb[1] && clear_ok;
      end else if (q.widx == IDX_IRQ_ENABLE) begin
        d.channel_irq_mask = merge8(q.channel_irq_mask, wbyte, wmask);
        if (q.wstrb[1]) begin
          d.overflow_irq_enable = q.wdata[IRQ_OVF_BIT];
        end
      end else if (q.widx == IDX_IRQ_STATUS) begin
        w_hit = 1'b1;
      end else begin
        w_hit = 1'b0;
      end
      d.bvalid = 1'b1;
      d.bresp = w_hit ? RESP_OKAY : RESP_SLVERR;
    end

    // write response retires, both channels reopen
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.awready = 1'b1;
      d.wready = 1'b1;
    end

    // read decode
    rd_do = q.arready && s_axi_arvalid;
    if (ridx == IDX_IO_SELECT) begin
      rd_val[7:0] = q.io_select;
    end else if (ridx == IDX_COUNT_HI) begin
      rd_val[7:0] = q.counter[15:8];
    end else if (ridx == IDX_COUNT_LO) begin
      rd_val[7:0] = q.counter[7:0];
    end else if (ridx == IDX_CTRL_ONE) begin
      rd_val[CTRL1_TIMER_EN] = q.timer_enable;
      rd_val[CTRL1_FAST_CLR] = q.fast_flag_clear;
    end else if (ridx == IDX_CHAN_MASK) begin
      rd_val[7:0] = q.channel_irq_mask;
    end else if (ridx == IDX_CTRL_TWO) begin
      rd_val[CTRL2_OVF_IE] = q.overflow_irq_enable;
      rd_val[CTRL2_CNT_RST] = q.counter_reset_on_match;
      rd_val[DIV_W-1:0] = q.clock_divider_select;
    end else if (ridx == IDX_CHAN_FLAGS) begin
      rd_val[7:0] = q.chan_flags;
    end else if (ridx == IDX_OVF_FLAGS) begin
      rd_val[OVF_FLAG_BIT] = q.overflow_flag;
    end else if (ridx == IDX_CMP7_HI) begin
      rd_val[7:0] = q.compare7_value[15:8];
    end else if (ridx == IDX_CMP7_LO) begin
      rd_val[7:0] = q.compare7_value[7:0];
    end else if (in_chan_win(ridx)) begin
      rd_val = RST_WORD; // other channel values live outside
    end else if (ridx == IDX_PACC_CTRL) begin
      rd_val[PACC_EN_BIT] = q.pulse_acc_enable;
    end else if (ridx == IDX_IRQ_STATUS) begin
      rd_val[7:0] = q.chan_flags;
      rd_val[IRQ_OVF_BIT] = q.overflow_flag;
    end else if (ridx == IDX_IRQ_ENABLE) begin
      rd_val[7:0] = q.channel_irq_mask;
      rd_val[IRQ_OVF_BIT] = q.overflow_irq_enable;
    end else if (ridx == IDX_IRQ_CLEAR) begin
      rd_val = RST_WORD; // write-only
    end else begin
      r_hit = 1'b0;
    end

    // read taken: answer next cycle, side effects now
    if (rd_do) begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rdata = rd_val;
      d.rresp = r_hit ? RESP_OKAY : RESP_SLVERR;
      if (ridx == IDX_COUNT_HI || ridx == IDX_COUNT_LO) begin
        clr_ovf = clr_ovf || q.fast_flag_clear;
      end else if (in_chan_win(ridx) && !q.io_select[chan_of(ridx)]) begin
        clr_ch[chan_of(ridx)] = clr_ch[chan_of(ridx)]
                                || q.fast_flag_clear;
      end
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end

    // counter: match reset outranks the timer tick
    match = q.timer_enable && q.counter_reset_on_match
            && q.io_select[CMP_CHANNEL]
            && (q.counter == q.compare7_value);
    set_ovf = tick && (q.counter == COUNT_MAX) && !match;
    if (match) begin
      d.counter = RST_COUNT;
    end else if (tick) begin
      d.counter = q.counter + COUNT_ONE;
    end

    // sticky flags, a set in the clearing cycle survives
    d.chan_flags = (q.chan_flags & ~clr_ch) | chan_event;
    d.overflow_flag = (q.overflow_flag && !clr_ovf) || set_ovf;

    // interrupt level from enabled flags
    d.irq = (d.overflow_flag && d.overflow_irq_enable)
            || |(d.chan_flags & d.channel_irq_mask);
  end

  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
      q.io_select <= RST_BYTE;
      q.channel_irq_mask <= RST_BYTE;
      q.chan_flags <= RST_BYTE;
      q.clock_divider_select <= RST_DIV;
      q.counter <= RST_COUNT;
      q.compare7_value <= RST_COUNT;
      q.rdata <= RST_WORD;
      q.bresp <= RESP_OKAY;
      q.rresp <= RESP_OKAY;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign free_counter = q.counter;
  assign irq = q.irq;

endmodule // timer_prescale_and_flags

// ===== sim/timer_prescale_and_flags_props.sv
`timescale 1ns/100ps

// ******
// port-level checks of the timer flags block
// ******
module timer_flags_checker
  import timer_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic aclk, // bus clock
  input wire logic aresetn, // sync reset, low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic [2:0] s_axi_awprot, // unused
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic [DATA_W-1:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // strobes
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // b response
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic [2:0] s_axi_arprot, // unused
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [DATA_W-1:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // r response
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic [CHANNELS-1:0] chan_event, // event strobes
  input wire logic [CNT_W-1:0] free_counter, // running count
  input wire logic irq // level interrupt
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // reset clears count and interrupt
  reset_clear_a: assert property (disable iff (1'b0)
    !aresetn |=> free_counter == RST_COUNT && !irq)
    else $error("count or irq not cleared by reset");
  // counter only steps by one or returns to zero
  count_step_a: assert property ($changed(free_counter) |->
    free_counter == $past(free_counter) + COUNT_ONE ||
    free_counter == RST_COUNT)
    else $error("counter jumped");
  // maximum is followed by itself or zero
  wrap_zero_a: assert property (free_counter == COUNT_MAX |=>
    free_counter == COUNT_MAX || free_counter == RST_COUNT)
    else $error("counter did not wrap to zero");
  // bus answer timing and release
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read data late");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not released");
  r_release_a: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid && s_axi_arready) else $error("read not released");
  busy_ready_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("ready while busy");
  err_data_a: assert property (s_axi_rvalid &&
    s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == RST_WORD)
    else $error("error read returned data");
endmodule // timer_flags_checker

// ===== sim/timer_prescale_and_flags_test.sv
`timescale 1ns/100ps

module timer_prescale_and_flags_test;
  import timer_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, chan_event;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [3:0] s_axi_wstrb;
  logic [15:0] free_counter;
  int miscompares = 0;
  int total_checks = 0;
  int n;

  // ******
  // clock, design and helpers
  // ******
  // 200 MHz bus clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  timer_prescale_and_flags #(.ADDR_W(8)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1),
    .chan_event(chan_event), .free_counter(free_counter), .irq(irq)
  );

  task automatic summarize();
    if (miscompares == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one write; ready held high so the answer is taken on arrival
  task automatic wr(input logic [5:0] idx, input logic [8:0] v,
                    input logic [3:0] s = 4'hF);
    int i;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {23'h0, v};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (i == 50) begin
      miscompares++;
      summarize();
    end
  endtask

  // one read, data and response taken at the handshake edge
  task automatic rd(input logic [5:0] idx);
    int i;
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (i == 50) begin
      miscompares++;
      summarize();
    end
  endtask

  task automatic expect_rd(input string what, input logic [5:0] idx,
                           input logic [31:0] exp);
    rd(idx);
    check(what, d, exp);
  endtask

  // cycles between two arrivals of the count at four
  task automatic period(input int exp);
    logic [15:0] prev;
    int i, p;
    p = -1;
    prev = free_counter;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (free_counter === 16'h0004 && prev !== 16'h0004) begin
        if (p >= 0) break;
        p = 0;
      end
      if (p >= 0) p++;
      prev = free_counter;
    end
    check("period", 32'(p), 32'(exp));
  endtask

  // ******
  // main sequence
  // ******
  initial begin
    aresetn = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    chan_event = 8'h00;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    expect_rd("ctrl two reset", IDX_CTRL_TWO, 32'h0);
    rd(6'h3F);
    check("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    // events on four channels, clear ignored with timer off
    chan_event <= 8'hA5;
    @(posedge aclk);
    chan_event <= 8'h00;
    expect_rd("flags set", IDX_CHAN_FLAGS, 32'hA5);
    wr(IDX_CHAN_FLAGS, 9'hFF);
    expect_rd("clear while off", IDX_CHAN_FLAGS, 32'hA5);
    // modulus mode with compare zero holds the count
    wr(IDX_IO_SELECT, 9'h80);
    wr(IDX_CTRL_TWO, 9'h08);
    wr(IDX_CTRL_ONE, 9'h80);
    for (n = 0; n < 20; n++) begin
      @(posedge aclk);
      check("held count", {16'h0, free_counter}, 32'h0);
    end
    wr(IDX_CHAN_FLAGS, 9'h00);
    expect_rd("write zero", IDX_CHAN_FLAGS, 32'hA5);
    @(posedge aclk);
    check("masked irq", {31'h0, irq}, 32'h0);
    wr(IDX_CHAN_MASK, 9'h01);
    @(posedge aclk);
    check("unmasked irq", {31'h0, irq}, 32'h1);
    wr(IDX_CHAN_FLAGS, 9'h01);
    expect_rd("flag cleared", IDX_CHAN_FLAGS, 32'hA4);
    @(posedge aclk);
    check("irq after clear", {31'h0, irq}, 32'h0);
    // overflow enable needs lane one: mask written, enable not
    wr(IDX_IRQ_ENABLE, 9'h101, 4'h1);
    expect_rd("lane one off", IDX_IRQ_ENABLE, 32'h1);
    // modulus periods at divide by one and two
    wr(IDX_CMP7_LO, 9'h04);
    period(5);
    wr(IDX_CTRL_TWO, 9'h09);
    // first period after a divider switch is short
    repeat (20) @(posedge aclk);
    period(9);
    // free run to the wrap with overflow interrupt on
    wr(IDX_CTRL_TWO, 9'h80);
    for (n = 0; n < 70000; n++) begin
      @(posedge aclk);
      if (irq === 1'b1) break;
    end
    check("overflow irq", {31'h0, irq}, 32'h1);
    expect_rd("overflow flag", IDX_OVF_FLAGS, 32'h80);
    expect_rd("irq status", IDX_IRQ_STATUS, 32'h1A4);
    wr(IDX_OVF_FLAGS, 9'h80);
    expect_rd("overflow clear", IDX_OVF_FLAGS, 32'h0);
    check("irq dropped", {31'h0, irq}, 32'h0);
    // fast clear: capture read of channel 2, compare write of 7
    wr(IDX_CTRL_ONE, 9'h90);
    rd(6'h14);
    wr(IDX_CMP7_LO, 9'h04);
    expect_rd("fast clear", IDX_CHAN_FLAGS, 32'h20);
    summarize();
  end
endmodule // timer_prescale_and_flags_test

bind timer_prescale_and_flags timer_flags_checker #(.ADDR_W(ADDR_W)) chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .chan_event(chan_event), .free_counter(free_counter), .irq(irq)
);
